/* File: nvls_pkg.sv */
// package for the non-volatile register load/store engine
package nvls_pkg;
    localparam logic [7:0]  CMD_LOAD_ONE      = 8'hc7;
    localparam logic [7:0]  CMD_STORE_MULTI   = 8'hc4;
    localparam logic [7:0]  CMD_STORE_ONE     = 8'hc6;
    localparam logic [7:0]  CMD_BUF_LONG      = 8'h8a;
    localparam logic [7:0]  REG_ACCUM         = 8'h0a;
    localparam logic [7:0]  REG_ARRAY_LO      = 8'h0a;
    localparam logic [7:0]  REG_ARRAY_HI      = 8'hc7;
    localparam logic [7:0]  REG_WRITABLE_LO   = 8'h0a;
    localparam logic [3:0]  COUNT_MAX         = 4'ha;
    localparam int          NUM_REGS          = 256;
    localparam logic [15:0] PROT_LIMIT_RST    = 16'h0000;
    localparam int          PSW_LOAD_FAIL_A   = 12;
    localparam int          PSW_LOAD_FAIL_B   = 14;
    localparam logic [3:0]  REG_ADR_CTRL      = 4'h0;
    localparam logic [3:0]  REG_ADR_STATUS    = 4'h1;
    localparam logic [3:0]  REG_ADR_IRQ_STAT  = 4'h2;
    localparam logic [3:0]  REG_ADR_IRQ_MASK  = 4'h3;
    localparam logic [3:0]  REG_ADR_PROT      = 4'h4;
    localparam logic [3:0]  REG_ADR_PSW       = 4'h5;
    localparam logic [3:0]  REG_ADR_ISW       = 4'h6;
    localparam logic [3:0]  REG_ADR_DATA_SEL  = 4'h7;
    localparam logic [3:0]  REG_ADR_DATA_VAL  = 4'h8;
    localparam int          IRQ_DONE          = 0;
    localparam int          IRQ_ERROR         = 1;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic [15:0] p1;
        logic [15:0] p2;
        logic [15:0] p3;
    } nvls_cmd_t;

    typedef struct packed {
        logic        req;
        logic        we;
        logic [15:0] addr;
        logic [15:0] wdata;
    } nvls_mem_t;

    typedef struct packed {
        logic        req;
        logic [15:0] addr;
        logic [31:0] wdata;
    } nvls_buf_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_SETUP = 3'b001,
        ST_WLO   = 3'b010,
        ST_WHI   = 3'b011,
        ST_WSUM  = 3'b100,
        ST_RD    = 3'b101,
        ST_BUF   = 3'b110,
        ST_DONE  = 3'b111
    } nvls_state_t;
endpackage

/* File: nvls_engine.sv */
// non-volatile register load/store engine with two-thread arbitration
`timescale 1ns/100ps
module nvls_engine
    import nvls_pkg::*;
(
    input  wire logic               I_CLOCK,      // 200 MHz clock
    input  wire logic               I_RST,        // async reset, high
    input  wire nvls_pkg::nvls_cmd_t I_CMD0,      // thread 1 command
    input  wire nvls_pkg::nvls_cmd_t I_CMD1,      // thread 2 command
    output logic [1:0]              O_STALL,      // per-thread stall
    output logic [1:0]              O_RETIRE,     // per-thread retire pulse
    output logic [1:0]              O_CMD_ERR,    // per-thread command error pulse
    output nvls_pkg::nvls_mem_t     O_MEM,        // memory request
    input  wire logic [15:0]        I_MEM_RDATA,  // memory read data, in the request cycle
    output nvls_pkg::nvls_buf_t     O_BUF,        // program buffer longword write
    input  wire logic [3:0]         I_ADDR,       // register address
    input  wire logic [31:0]        I_WDATA,      // register write data
    input  wire logic               I_WR,         // write strobe
    input  wire logic               I_RD,         // read strobe
    output logic [31:0]             O_RDATA,      // read data, one cycle later
    output logic                    O_IRQ         // level interrupt
);
    import nvls_pkg::*;

    logic [31:0] data_regs [NUM_REGS];
    nvls_state_t state;
    logic        owner;
    nvls_cmd_t   cmd;
    logic [7:0]  cur_reg;
    logic [3:0]  remain;
    logic [15:0] mem_adr;
    logic [15:0] csum;
    logic        suppress;
    logic        failed;
    logic [1:0]  rd_phase;
    logic [15:0] rd_lo;
    logic [15:0] prot_limit;
    logic [15:0] polling_status_word;
    logic [2:0]  internal_status_word;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [7:0]  data_sel;
    logic        ev_done;
    logic        ev_err;
    logic        grant;
    logic        next_owner;
    nvls_cmd_t   pick;
    logic [1:0]  want;
    logic        last_bad;

    function automatic logic [7:0] reg_mag(input logic [15:0] p);
        logic [15:0] m;
        m = p[15] ? 16'(-p) : p;
        return m[7:0];
    endfunction

    function automatic logic [15:0] sum_add(input logic [15:0] s, input logic [15:0] w);
        return 16'(s + w);
    endfunction

    // fixed priority to thread 1 unless thread 2 waits alone
    // a thread still showing its retire pulse is not taken again
    always_comb begin
        want[0]    = I_CMD0.valid && !O_RETIRE[0];
        want[1]    = I_CMD1.valid && !O_RETIRE[1];
        grant      = (state == ST_IDLE) && (|want);
        next_owner = !want[0];
        pick       = next_owner ? I_CMD1 : I_CMD0;
    end

    // stall each thread whose command is pending and not retiring
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_STALL <= 2'b00;
        end else begin
            O_STALL[0] <= want[0] && !(state == ST_DONE && owner == 1'b0);
            O_STALL[1] <= want[1] && !(state == ST_DONE && owner == 1'b1);
        end
    end

    // main sequencer
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            state    <= ST_IDLE;
            owner    <= 1'b0;
            cmd      <= '0;
            cur_reg  <= 8'h00;
            remain   <= 4'h0;
            mem_adr  <= 16'h0000;
            csum     <= 16'h0000;
            suppress <= 1'b0;
            failed   <= 1'b0;
            rd_phase <= 2'b00;
            rd_lo    <= 16'h0000;
            O_MEM    <= '0;
            O_BUF    <= '0;
        end else begin
            O_MEM.req <= 1'b0;
            O_BUF.req <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (grant) begin
                        owner <= next_owner;
                        cmd   <= pick;
                        state <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    failed   <= 1'b0;
                    csum     <= 16'h0000;
                    rd_phase <= 2'b00;
                    state    <= ST_DONE;
                    if (cmd.code == CMD_STORE_MULTI) begin
                        suppress <= cmd.p2[15];
                        cur_reg  <= reg_mag(cmd.p2);
                        remain   <= cmd.p1[3:0];
                        mem_adr  <= (cmd.p3 == 16'h0000) ? data_regs[REG_ACCUM][15:0] : cmd.p3;
                        if (cmd.p1 == 16'h0000 || cmd.p1 > 16'(COUNT_MAX)) begin
                            failed <= 1'b1;
                        end else if (((cmd.p3 == 16'h0000) ? data_regs[REG_ACCUM][15:0] : cmd.p3)
                                     < prot_limit) begin
                            failed <= 1'b1;
                        end else begin
                            state <= ST_WLO;
                        end
                    end else if (cmd.code == CMD_STORE_ONE || cmd.code == CMD_LOAD_ONE) begin
                        suppress <= cmd.p1[15];
                        cur_reg  <= reg_mag(cmd.p1);
                        remain   <= 4'h1;
                        mem_adr  <= (cmd.p2 == 16'h0000) ? data_regs[REG_ACCUM][15:0] : cmd.p2;
                        if (cmd.code == CMD_LOAD_ONE) begin
                            if (reg_mag(cmd.p1) < REG_WRITABLE_LO) begin
                                failed <= 1'b1;
                            end else begin
                                state <= ST_RD;
                            end
                        end else if (((cmd.p2 == 16'h0000) ? data_regs[REG_ACCUM][15:0] : cmd.p2)
                                     < prot_limit) begin
                            failed <= 1'b1;
                        end else begin
                            state <= ST_WLO;
                        end
                    end else if (cmd.code == CMD_BUF_LONG) begin
                        state <= ST_BUF;
                    end else begin
                        failed <= 1'b1;
                    end
                end
                ST_WLO: begin
                    O_MEM <= '{req: 1'b1, we: 1'b1, addr: mem_adr, wdata: data_regs[cur_reg][15:0]};
                    csum    <= sum_add(csum, data_regs[cur_reg][15:0]);
                    mem_adr <= 16'(mem_adr + 16'h0001);
                    state   <= ST_WHI;
                end
                ST_WHI: begin
                    O_MEM <= '{req: 1'b1, we: 1'b1, addr: mem_adr, wdata: data_regs[cur_reg][31:16]};
                    csum    <= sum_add(csum, data_regs[cur_reg][31:16]);
                    mem_adr <= 16'(mem_adr + 16'h0001);
                    cur_reg <= 8'(cur_reg + 8'h01);
                    remain  <= 4'(remain - 4'h1);
                    state   <= (remain == 4'h1) ? ST_WSUM : ST_WLO;
                end
                ST_WSUM: begin
                    O_MEM <= '{req: 1'b1, we: 1'b1, addr: mem_adr, wdata: csum};
                    state <= ST_DONE;
                end
                ST_RD: begin
                    rd_phase <= 2'(rd_phase + 2'b01);
                    if (rd_phase < 2'd3) begin
                        O_MEM <= '{req: 1'b1, we: 1'b0, addr: 16'(mem_adr + 16'(rd_phase)), wdata: 16'h0000};
                    end
                    if (rd_phase == 2'd2) begin
                        rd_lo <= I_MEM_RDATA;
                        csum  <= sum_add(csum, I_MEM_RDATA);
                    end else if (rd_phase == 2'd3) begin
                        rd_lo <= I_MEM_RDATA;
                        csum  <= sum_add(csum, I_MEM_RDATA);
                        state <= ST_DONE;
                    end
                    if (rd_phase == 2'd1) begin
                        csum <= sum_add(16'h0000, I_MEM_RDATA);
                        rd_lo <= I_MEM_RDATA;
                    end
                end
                ST_BUF: begin
                    O_BUF <= '{req: 1'b1, addr: cmd.p2, wdata: data_regs[reg_mag(cmd.p1)]};
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // load data capture: low, high, then checksum word
    logic [15:0] ld_lo;
    logic [15:0] ld_hi;
    always_ff @(posedge I_CLOCK) begin
        if (state == ST_RD && rd_phase == 2'd1) begin
            ld_lo <= I_MEM_RDATA;
        end
        if (state == ST_RD && rd_phase == 2'd2) begin
            ld_hi <= I_MEM_RDATA;
        end
    end

    logic ld_bad;
    assign ld_bad = (state == ST_RD && rd_phase == 2'd3) && (I_MEM_RDATA != 16'(ld_lo + ld_hi));

    // data register file; load write-back and software access
    always_ff @(posedge I_CLOCK) begin
        if (state == ST_RD && rd_phase == 2'd3 && !ld_bad) begin
            data_regs[cur_reg] <= {ld_hi, ld_lo};
        end else if (I_WR && I_ADDR == REG_ADR_DATA_VAL) begin
            data_regs[data_sel] <= I_WDATA;
        end
    end

    // completion: results, flags and events
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            O_RETIRE  <= 2'b00;
            O_CMD_ERR <= 2'b00;
            polling_status_word       <= 16'h0000;
            internal_status_word       <= 3'b000;
            ev_done   <= 1'b0;
            ev_err    <= 1'b0;
        end else begin
            O_RETIRE  <= 2'b00;
            O_CMD_ERR <= 2'b00;
            ev_done   <= 1'b0;
            ev_err    <= 1'b0;
            // clear first so a flag raised in the same cycle wins
            if (I_WR && I_ADDR == REG_ADR_PSW) begin
                polling_status_word <= polling_status_word & ~I_WDATA[15:0];
            end
            if (ld_bad) begin
                polling_status_word[PSW_LOAD_FAIL_A] <= 1'b1;
                polling_status_word[PSW_LOAD_FAIL_B] <= 1'b1;
            end
            if (state == ST_SETUP && cmd.code != CMD_LOAD_ONE && cmd.code != CMD_BUF_LONG) begin
                if ((cmd.code == CMD_STORE_MULTI && ((cmd.p3 == 16'h0000) ? data_regs[REG_ACCUM][15:0] : cmd.p3)
                     < prot_limit) || (cmd.code == CMD_STORE_ONE
                     && ((cmd.p2 == 16'h0000) ? data_regs[REG_ACCUM][15:0] : cmd.p2) < prot_limit)) begin
                    polling_status_word[PSW_LOAD_FAIL_A] <= 1'b1;
                    polling_status_word[PSW_LOAD_FAIL_B] <= 1'b1;
                end
            end
            if (state == ST_DONE) begin
                O_RETIRE[owner] <= 1'b1;
                ev_done         <= 1'b1;
                if (failed || polling_status_word[PSW_LOAD_FAIL_A] && cmd.code != CMD_BUF_LONG && last_bad) begin
                    internal_status_word         <= 3'b001;
                    ev_err      <= 1'b1;
                    O_CMD_ERR[owner] <= !suppress;
                end else if (cmd.code != CMD_BUF_LONG) begin
                    internal_status_word <= 3'b100;
                end
            end
        end
    end

    // remember a checksum failure of the running load
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            last_bad <= 1'b0;
        end else if (state == ST_SETUP) begin
            last_bad <= 1'b0;
        end else if (ld_bad) begin
            last_bad <= 1'b1;
        end
    end

    // software registers
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            prot_limit <= PROT_LIMIT_RST;
            irq_mask   <= 2'b00;
            irq_stat   <= 2'b00;
            data_sel   <= 8'h00;
            O_RDATA    <= 32'h0000_0000;
            O_IRQ      <= 1'b0;
        end else begin
            if (I_WR && I_ADDR == REG_ADR_PROT) prot_limit <= I_WDATA[15:0];
            if (I_WR && I_ADDR == REG_ADR_IRQ_MASK) irq_mask <= I_WDATA[1:0];
            if (I_WR && I_ADDR == REG_ADR_DATA_SEL) data_sel <= I_WDATA[7:0];
            irq_stat <= (irq_stat & ~((I_WR && I_ADDR == REG_ADR_IRQ_STAT) ? I_WDATA[1:0] : 2'b00))
                        | {ev_err, ev_done};
            O_IRQ <= |(irq_stat & irq_mask);
            O_RDATA <= 32'h0000_0000;
            if (I_RD) begin
                unique case (I_ADDR)
                    REG_ADR_STATUS:   O_RDATA <= {27'h0, owner, state != ST_IDLE, state};
                    REG_ADR_IRQ_STAT: O_RDATA <= {30'h0, irq_stat};
                    REG_ADR_IRQ_MASK: O_RDATA <= {30'h0, irq_mask};
                    REG_ADR_PROT:     O_RDATA <= {16'h0, prot_limit};
                    REG_ADR_PSW:      O_RDATA <= {16'h0, polling_status_word};
                    REG_ADR_ISW:      O_RDATA <= {29'h0, internal_status_word};
                    REG_ADR_DATA_SEL: O_RDATA <= {24'h0, data_sel};
                    REG_ADR_DATA_VAL: O_RDATA <= data_regs[data_sel];
                    default:          O_RDATA <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule

/* File: nvls_checker.sv */
// port assertions for the non-volatile load/store engine
`timescale 1ns/100ps
module nvls_checker
    import nvls_pkg::*;
(
    input  wire logic                I_CLOCK,   // clock
    input  wire logic                I_RST,     // async reset
    input  wire nvls_pkg::nvls_cmd_t I_CMD0,    // thread 1 command
    input  wire nvls_pkg::nvls_cmd_t I_CMD1,    // thread 2 command
    input  wire logic [1:0]          O_STALL,   // stalls
    input  wire logic [1:0]          O_RETIRE,  // retire pulses
    input  wire logic [1:0]          O_CMD_ERR, // error pulses
    input  wire nvls_pkg::nvls_mem_t O_MEM,     // memory request
    input  wire nvls_pkg::nvls_buf_t O_BUF      // buffer write
);
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);

    a_retire_pulse: assert property (O_RETIRE[0] |=> !O_RETIRE[0])
        else $error("retire longer than one cycle");
    a_single_owner: assert property (!(&O_RETIRE))
        else $error("both threads retired together");
    a_err_retire: assert property (O_CMD_ERR[0] |-> O_RETIRE[0])
        else $error("error pulse without retire");
    a_neg_quiet: assert property (O_RETIRE[0] && I_CMD0.code == CMD_LOAD_ONE && I_CMD0.p1[15] |-> !O_CMD_ERR[0])
        else $error("error not suppressed");
    a_word_order: assert property (O_MEM.req && O_MEM.we |=> !O_MEM.req || (O_MEM.we && O_MEM.addr == $past(O_MEM.addr) + 16'h1))
        else $error("store words not successive");
    a_write_stalled: assert property (O_MEM.req && O_MEM.we |-> |O_STALL)
        else $error("write while no thread stalled");
    a_retire_clean: assert property (|O_RETIRE |-> !O_MEM.req)
        else $error("retire with memory busy");
    a_buf_source: assert property (O_BUF.req |-> (I_CMD0.valid && I_CMD0.code == CMD_BUF_LONG && O_BUF.addr == I_CMD0.p2)
        || (I_CMD1.valid && I_CMD1.code == CMD_BUF_LONG && O_BUF.addr == I_CMD1.p2))
        else $error("buffer write without command");
    a_load_finish: assert property (O_MEM.req && !O_MEM.we |-> ##[1:8] (|O_RETIRE))
        else $error("load not finished");
    a_stall_hold: assert property (O_STALL[1] && !O_RETIRE[1] |=> O_STALL[1] || O_RETIRE[1])
        else $error("thread 2 stall dropped early");

    c_buf: cover property (O_BUF.req);
    c_err: cover property (O_CMD_ERR[0]);
    c_both: cover property (O_STALL == 2'b11);
    c_store: cover property (O_MEM.req && O_MEM.we);
endmodule

bind nvls_engine nvls_checker nvls_checker_inst (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_CMD0(I_CMD0), .I_CMD1(I_CMD1),
    .O_STALL(O_STALL), .O_RETIRE(O_RETIRE), .O_CMD_ERR(O_CMD_ERR), .O_MEM(O_MEM), .O_BUF(O_BUF));

/* File: nvls_mem_model.sv */
// non-volatile memory model on the far side of the engine
`timescale 1ns/100ps
module nvls_mem_model
    import nvls_pkg::*;
(
    input  wire logic                i_clock, // clock
    input  wire nvls_pkg::nvls_mem_t i_mem,   // word request
    output logic [15:0]              o_rdata  // read word, within the request cycle
);
    logic [15:0] mem [int];
    initial o_rdata = 16'h0;
    always @(posedge i_clock) begin
        if (i_mem.req && i_mem.we) begin
            mem[int'(i_mem.addr)] = i_mem.wdata;
        end
    end
    // engine samples the word at the edge that ends its request
    // idle cycles show a changing pattern, not the last word
    always @(negedge i_clock) begin
        if (i_mem.req && !i_mem.we) begin
            o_rdata <= mem.exists(int'(i_mem.addr)) ? mem[int'(i_mem.addr)] : 16'hffff;
        end else begin
            o_rdata <= ~o_rdata;
        end
    end
endmodule

/* File: nvls_engine_tb.sv */
// self-checking bench for the non-volatile load/store engine
`timescale 1ns/100ps
module nvls_engine_tb;
    import nvls_pkg::*;
    logic        clock, rst, wr, rd, irq;
    nvls_cmd_t   cmd [2];
    logic [1:0]  stall, retire, cmd_err;
    nvls_mem_t   mem;
    nvls_buf_t   buf_w, buf_seen;
    logic [15:0] mem_rdata;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, got;
    logic [31:0] ref_reg [256];
    logic        err_seen [2];
    int          t_ret [2];
    int          n_mismatch, checked;
    bit   [31:0] seed;

    nvls_engine nvls_engine_inst (.I_CLOCK(clock), .I_RST(rst), .I_CMD0(cmd[0]), .I_CMD1(cmd[1]), .O_STALL(stall),
        .O_RETIRE(retire), .O_CMD_ERR(cmd_err), .O_MEM(mem), .I_MEM_RDATA(mem_rdata), .O_BUF(buf_w), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .O_IRQ(irq));
    nvls_mem_model nvls_mem_model_inst (.i_clock(clock), .i_mem(mem), .o_rdata(mem_rdata));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) begin
        if (buf_w.req) begin
            buf_seen <= buf_w;
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic reg_wr(logic [3:0] a, logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic reg_rd(logic [3:0] a, output logic [31:0] r);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        @(negedge clock);
        r = rdata;
    endtask
    task automatic set_reg(logic [31:0] n, logic [31:0] d);
        reg_wr(REG_ADR_DATA_SEL, n);
        reg_wr(REG_ADR_DATA_VAL, d);
        ref_reg[n] = d;
    endtask
    task automatic get_reg(logic [31:0] n, output logic [31:0] r);
        reg_wr(REG_ADR_DATA_SEL, n);
        reg_rd(REG_ADR_DATA_VAL, r);
    endtask
    task automatic run_cmd(int t, logic [7:0] c, logic [15:0] a, logic [15:0] b, logic [15:0] d);
        int k;
        k = 0;
        @(posedge clock);
        cmd[t] <= '{1'b1, c, a, b, d};
        do begin
            @(negedge clock);
            k++;
        end while (retire[t] !== 1'b1 && k < 200);
        if (retire[t] !== 1'b1) begin
            n_mismatch++;
            test_done();
        end
        err_seen[t] = cmd_err[t];
        t_ret[t] = $time;
        @(posedge clock);
        cmd[t] <= '0;
    endtask
    task automatic store_check(int n, int s, int a);
        logic [15:0] sum;
        sum = 16'h0;
        for (int i = 0; i < n; i++) begin
            check("lo word", nvls_mem_model_inst.mem[a + 2 * i], ref_reg[s + i][15:0]);
            check("hi word", nvls_mem_model_inst.mem[a + 2 * i + 1], ref_reg[s + i][31:16]);
            sum += ref_reg[s + i][15:0] + ref_reg[s + i][31:16];
        end
        check("checksum", nvls_mem_model_inst.mem[a + 2 * n], sum);
    endtask

    initial begin
        seed = 32'hf7fc50c1;
        {rst, wr, rd, addr, wdata, n_mismatch, checked} = '0;
        rst = 1'b1;
        cmd[0] = '0;
        cmd[1] = '0;
        buf_seen = '0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        reg_rd(REG_ADR_PROT, got);
        check("prot reset", got, 32'(PROT_LIMIT_RST));
        reg_rd(4'hf, got);
        check("unmapped", got, 32'h0);
        // count 5 and the top count 10 ending on the last array register
        for (int i = 0; i < 10; i++) set_reg(20 + i, xs());
        for (int i = 0; i < 10; i++) set_reg(190 + i, xs());
        run_cmd(0, CMD_STORE_MULTI, 16'd5, 16'd20, 16'h0100);
        store_check(5, 20, 'h100);
        run_cmd(0, CMD_STORE_MULTI, 16'd10, 16'd190, 16'h0300);
        store_check(10, 190, 'h300);
        run_cmd(0, CMD_STORE_MULTI, 16'd11, 16'd20, 16'h0600);
        check("count 11 err", err_seen[0], 1'b1);
        set_reg(3, xs());
        run_cmd(0, CMD_STORE_ONE, 16'd3, 16'h0200, 16'h0);
        store_check(1, 3, 'h200);
        run_cmd(0, CMD_LOAD_ONE, 16'd30, 16'h0200, 16'h0);
        get_reg(30, got);
        check("load", got, ref_reg[3]);
        reg_rd(REG_ADR_ISW, got);
        check("isw ok", got[2:0], 3'b100);
        set_reg(10, 32'h0000_0200);
        run_cmd(1, CMD_LOAD_ONE, 16'd31, 16'h0, 16'h0);
        get_reg(31, got);
        check("indirect", got, ref_reg[3]);
        nvls_mem_model_inst.mem['h202] ^= 16'h1;
        run_cmd(0, CMD_LOAD_ONE, 16'd32, 16'h0200, 16'h0);
        check("sum err", err_seen[0], 1'b1);
        reg_rd(REG_ADR_PSW, got);
        check("psw", {got[14], got[12]}, 2'b11);
        reg_wr(REG_ADR_PSW, 32'h5000);
        run_cmd(0, CMD_LOAD_ONE, 16'hffe0, 16'h0200, 16'h0);
        check("neg quiet", err_seen[0], 1'b0);
        reg_rd(REG_ADR_ISW, got);
        check("isw neg", got[0], 1'b1);
        nvls_mem_model_inst.mem['h202] ^= 16'h1;
        run_cmd(0, CMD_LOAD_ONE, 16'd5, 16'h0200, 16'h0);
        check("ro load", err_seen[0], 1'b1);
        reg_wr(REG_ADR_PROT, 32'h1000);
        reg_wr(REG_ADR_PSW, 32'h5000);
        run_cmd(0, CMD_STORE_ONE, 16'd3, 16'h0800, 16'h0);
        check("prot err", err_seen[0], 1'b1);
        check("prot write", nvls_mem_model_inst.mem.exists('h800), 32'h0);
        reg_rd(REG_ADR_PSW, got);
        check("prot psw", {got[14], got[12]}, 2'b11);
        reg_wr(REG_ADR_PROT, 32'h0);
        set_reg(40, xs() | 32'h8000_0000);
        run_cmd(0, CMD_BUF_LONG, 16'd40, 16'h007a, 16'h0);
        check("buf addr", buf_seen.addr, 32'h7a);
        check("buf data", buf_seen.wdata, ref_reg[40]);
        reg_wr(REG_ADR_IRQ_STAT, 32'h3);
        reg_wr(REG_ADR_IRQ_MASK, 32'h0);
        set_reg(51, xs());
        fork
            run_cmd(0, CMD_STORE_MULTI, 16'd2, 16'd20, 16'h0400);
            run_cmd(1, CMD_STORE_ONE, 16'd51, 16'h0500, 16'h0);
        join
        check("thread order", t_ret[0] < t_ret[1], 32'h1);
        store_check(2, 20, 'h400);
        store_check(1, 51, 'h500);
        reg_rd(REG_ADR_IRQ_STAT, got);
        check("done event", got[0], 1'b1);
        check("irq masked", irq, 1'b0);
        reg_wr(REG_ADR_IRQ_MASK, 32'h1);
        repeat (3) @(negedge clock);
        check("irq on", irq, 1'b1);
        reg_wr(REG_ADR_IRQ_STAT, 32'h1);
        repeat (3) @(negedge clock);
        check("irq clear", irq, 1'b0);
        test_done();
    end
endmodule
